// ===== logic/cab_analog_bank.sv
// indirect access port and decoded analog control outputs
// assumes the host writes the access word through accWr/accWdata in this clock
`timescale 1ns/1ns
module cab_analog_bank
	import cab_pkg::*;
#(
	parameter int CAL_LEN = CAL_CYCLES
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic accWr,
	input wire logic [31:0] accWdata,
	output logic [31:0] accRdata,
	input wire logic [5:0] calValue,
	input wire logic ampEnableReq,
	output logic analogPortReset_b,
	output logic ampClockGate,
	output logic ampEnable,
	output logic [5:0] headphoneVolume,
	output logic headphoneMute,
	output logic [6:0] leftMixerSourceMask,
	output logic [6:0] rightMixerSourceMask,
	output logic [2:0] secondMicBoostGain,
	output logic [2:0] secondMicMixerGain,
	output logic [2:0] lineInputMixerGain,
	output logic [2:0] adcInputGain,
	output logic rightAmpSourceSel,
	output logic leftAmpSourceSel,
	output logic rightAmpUnmute,
	output logic leftAmpUnmute,
	output logic zeroCrossActive,
	output logic zeroCrossLongTimeout,
	output logic biasUseManual,
	output logic calSingleShot,
	output logic calBusy,
	output logic headphoneBufferOn,
	output logic headphoneInputPass,
	output logic headphoneInputStageOn,
	output logic headphoneOutputStageOn,
	output logic [1:0] headphoneStartupDelay,
	output logic [1:0] detectPulldownDelay,
	output logic [NUM_REGS*8-1:0] bankFlat
);
	initial begin
		if (CAL_LEN < 1 || CAL_LEN > 65535) $error("calibration length out of range");
	end

	// ----------------------------------------------------------------
	// access word
	// ----------------------------------------------------------------
	logic [31:0] acc_reg;
	logic [31:0] acc_next;
	logic [7:0] rdByte;
	logic [5:0] calResult_reg;

	wire portRun = acc_reg[ACC_RST_BIT];
	wire [5:0] portAddr = acc_reg[ACC_ADDR_HI:ACC_ADDR_LO];
	// a write access fires once per host write with the direction and port run bits set
	wire bankWrite = accWr && accWdata[ACC_WR_BIT] && accWdata[ACC_RST_BIT];

	// host writes only the defined fields; low byte is read-back only
	assign acc_next = accWr ? (accWdata & ACC_RW_MASK) : acc_reg;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			acc_reg <= ACC_RESET;
		end else begin
			acc_reg <= acc_next;
		end
	end

	// low byte shows the addressed register one cycle after the address lands
	assign accRdata = {acc_reg[31:8], rdByte};
	assign analogPortReset_b = portRun;

	// ----------------------------------------------------------------
	// calibration sequencer
	// ----------------------------------------------------------------
	cab_cal_state_t calState_reg;
	cab_cal_state_t calState_next;
	logic [15:0] calCnt_reg;
	logic [15:0] calCnt_next;
	logic calDoneOnce_reg;
	logic calClear;

	wire [7:0] calCtl = bankFlat[OFS_CALCTL*8 +: 8];
	wire [7:0] hpCal = bankFlat[OFS_HPCAL*8 +: 8];
	wire [7:0] hpAmp = bankFlat[OFS_HP_AMP*8 +: 8];
	wire restartReq = calCtl[CAL_RESTART_BIT];
	// first amp enable waits for one calibration when asked
	wire needFirstCal = hpCal[HPCAL_FIRST_BIT] && !calDoneOnce_reg;
	wire ampWanted = hpAmp[HPAMP_EN_BIT] || ampEnableReq;
	wire startCal = restartReq || (ampWanted && needFirstCal);

	always_comb begin
		calState_next = calState_reg;
		calCnt_next = calCnt_reg;
		calClear = 1'b0;
		unique case (calState_reg)
			CAB_IDLE: begin
				if (startCal) begin
					calState_next = CAB_CAL;
					calCnt_next = 16'(CAL_LEN - 1);
				end
			end
			CAB_CAL: begin
				if (calCnt_reg == 16'h0000) begin
					calState_next = CAB_DONE;
				end else begin
					calCnt_next = calCnt_reg - 16'h0001;
				end
			end
			CAB_DONE: begin
				calClear = 1'b1;
				calState_next = CAB_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b || !portRun) begin
			calState_reg <= CAB_IDLE;
			calCnt_reg <= 16'h0000;
			calDoneOnce_reg <= 1'b0;
			calResult_reg <= 6'h00;
		end else begin
			calState_reg <= calState_next;
			calCnt_reg <= calCnt_next;
			if (calState_reg == CAB_DONE) begin
				calDoneOnce_reg <= 1'b1;
				// manual bias bypasses the measured value
				calResult_reg <= calCtl[CAL_MANUAL_BIT] ? calResult_reg : calValue;
			end
		end
	end

	assign calBusy = (calState_reg != CAB_IDLE);

	// ----------------------------------------------------------------
	// register bank
	// ----------------------------------------------------------------
	cab_reg_file #(
		.DEPTH(NUM_REGS)
	) u_regs (
		.clk(clk),
		.rst_b(rst_b),
		.portRst_b(portRun),
		.wrEn(bankWrite),
		.wrAddr(accWdata[ACC_ADDR_HI:ACC_ADDR_LO]),
		.wrData(accWdata[ACC_WDAT_HI:ACC_WDAT_LO]),
		.rdAddr(portAddr),
		.calResult({2'b00, calResult_reg}),
		.calClear(calClear),
		.rdData(rdByte),
		.regFlat(bankFlat)
	);

	// ----------------------------------------------------------------
	// decoded controls for the analog side
	// ----------------------------------------------------------------
	wire [7:0] lmix = bankFlat[OFS_LMIX*8 +: 8];
	wire [7:0] rmix = bankFlat[OFS_RMIX*8 +: 8];
	wire [7:0] mic2 = bankFlat[OFS_MIC2*8 +: 8];
	wire [7:0] linein = bankFlat[OFS_LINEIN*8 +: 8];
	wire [7:0] mixdac = bankFlat[OFS_MIXDAC*8 +: 8];
	wire [7:0] adc = bankFlat[OFS_ADC*8 +: 8];
	wire [7:0] zc = bankFlat[OFS_ZC*8 +: 8];
	wire [7:0] calSet = bankFlat[OFS_CALSET*8 +: 8];
	wire [7:0] hpStage = bankFlat[OFS_HPSTAGE*8 +: 8];

	assign ampClockGate = hpAmp[CLKGATE_BIT];
	// gated amp clock cannot time a zero crossing, so force it off
	assign zeroCrossActive = zc[ZC_EN_BIT] && !hpAmp[CLKGATE_BIT];
	assign zeroCrossLongTimeout = zc[ZC_TO_BIT];
	// amp held off during calibration and, when asked, until the first calibration has run
	assign ampEnable = ampWanted && !needFirstCal && !calBusy;
	assign headphoneVolume = hpAmp[5:0];
	assign headphoneMute = (hpAmp[5:0] == 6'h00);
	assign leftMixerSourceMask = lmix[6:0] & 7'h23;
	assign rightMixerSourceMask = rmix[6:0] & 7'h27;
	assign secondMicBoostGain = mic2[2:0];
	assign secondMicMixerGain = mic2[6:4];
	assign lineInputMixerGain = linein[2:0];
	assign adcInputGain = adc[2:0];
	assign rightAmpSourceSel = mixdac[1];
	assign leftAmpSourceSel = mixdac[0];
	assign rightAmpUnmute = mixdac[3];
	assign leftAmpUnmute = mixdac[2];
	assign biasUseManual = calCtl[CAL_MANUAL_BIT];
	assign calSingleShot = calCtl[CAL_SINGLE_BIT];
	assign headphoneBufferOn = hpStage[7];
	assign headphoneInputPass = hpStage[6];
	assign headphoneInputStageOn = hpStage[5];
	assign headphoneOutputStageOn = hpStage[4];
	assign headphoneStartupDelay = hpStage[3:2];
	assign detectPulldownDelay = calSet[7:6];
endmodule

// ===== logic/cab_pkg.sv
// constants for the analog control bank behind the indirect access word
// assumes one 125 MHz clock domain shared with the host access word
//
// Function
// - access word bit 28 holds the analog port in reset while zero; resets to one
// - access word bit 24 selects read (0) or write (1)
// - access word bits 21:16 carry the six-bit analog register address
// - access word bits 15:8 carry the write byte
// - access word bits 7:0 return the byte read from the addressed register
// - amp clock gate at 0x00 bit 7 forces zero-cross volume change off
// - headphone volume code gives 64 levels, 1dB steps; zero code mutes
// - left mixer mask bits unmute mic2 boost, left DAC, right DAC
// - right mixer mask bits unmute mic2 boost, right line input, right DAC, left DAC
// - mic2 boost gain 0dB at 000, then 24dB to 42dB in 3dB steps
// - line, mic2 mixer and ADC gains span -4.5dB to 6dB in 1.5dB steps
// - amp source bit picks same-side DAC at 0, same-side mixer at 1
// - amp unmute bits, right bit 3 left bit 2, pass inputs when one
// - 0x12 bit 7 enables zero-cross volume; bit 6 picks 32ms or 64ms timeout
// - writing one to calibration bit 1 restarts calibration and self-clears
// - calibration bit 0 picks manual bias; bit 2 picks single-shot calibration
// - offset 0x13 returns six-bit calibration result, read only
// - stage control bits 7..4 clear to disable buffer, inputs, input and output stage
// - startup delay field bits 3:2 select 4, 8, 16 or 32 ms
// - calibration-first bit makes one calibration run before amp enable
// - 0x14 bits 7:6 set detect pulldown delay 0.5 to 2 ms

package cab_pkg;
	// ----------------------------------------------------------------
	// access word layout
	// ----------------------------------------------------------------
	localparam int ACC_RST_BIT = 28;
	localparam int ACC_WR_BIT = 24;
	localparam int ACC_ADDR_HI = 21;
	localparam int ACC_ADDR_LO = 16;
	localparam int ACC_WDAT_HI = 15;
	localparam int ACC_WDAT_LO = 8;
	localparam logic [31:0] ACC_RESET = 32'h1000_0000;
	localparam logic [31:0] ACC_RW_MASK = 32'h113f_ff00;

	// ----------------------------------------------------------------
	// analog register offsets
	// ----------------------------------------------------------------
	localparam logic [5:0] OFS_HP_AMP = 6'h00;
	localparam logic [5:0] OFS_LMIX = 6'h01;
	localparam logic [5:0] OFS_RMIX = 6'h02;
	localparam logic [5:0] OFS_MIC2 = 6'h08;
	localparam logic [5:0] OFS_LINEIN = 6'h09;
	localparam logic [5:0] OFS_MIXDAC = 6'h0a;
	localparam logic [5:0] OFS_RADCMIX = 6'h0c;
	localparam logic [5:0] OFS_ADC = 6'h0d;
	localparam logic [5:0] OFS_MBIAS = 6'h0e;
	localparam logic [5:0] OFS_TUNE = 6'h0f;
	localparam logic [5:0] OFS_OPB0 = 6'h10;
	localparam logic [5:0] OFS_OPB1 = 6'h11;
	localparam logic [5:0] OFS_ZC = 6'h12;
	localparam logic [5:0] OFS_CALRES = 6'h13;
	localparam logic [5:0] OFS_CALSET = 6'h14;
	localparam logic [5:0] OFS_CALCTL = 6'h15;
	localparam logic [5:0] OFS_HPSTAGE = 6'h16;
	localparam logic [5:0] OFS_HPCAL = 6'h17;
	localparam int NUM_REGS = 24;

	// ----------------------------------------------------------------
	// reset values and writable-bit masks, indexed by offset
	// ----------------------------------------------------------------
	localparam logic [NUM_REGS*8-1:0] RESET_TABLE = {
		8'h04, 8'hf1, 8'h00, 8'h20, 8'h00, 8'h02, 8'h55, 8'h55,
		8'hd6, 8'h21, 8'h03, 8'h00, 8'h00, 8'h00, 8'h03, 8'hb4,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [NUM_REGS*8-1:0] WMASK_TABLE = {
		8'hbf, 8'hff, 8'hff, 8'hff, 8'h00, 8'hc7, 8'hff, 8'hff,
		8'hff, 8'he3, 8'hf7, 8'h7f, 8'h00, 8'hff, 8'h07, 8'hff,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h7f, 8'h7f, 8'hff};

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CLKGATE_BIT = 7;
	localparam int ZC_EN_BIT = 7;
	localparam int ZC_TO_BIT = 6;
	localparam int CAL_RESTART_BIT = 1;
	localparam int CAL_SINGLE_BIT = 2;
	localparam int CAL_MANUAL_BIT = 0;
	localparam int HPCAL_FIRST_BIT = 7;
	localparam int HPAMP_EN_BIT = 6;

	// ----------------------------------------------------------------
	// timing, 125 MHz clock
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int CAL_TIME_US = 1;
	localparam int CAL_CYCLES = CAL_TIME_US * CLK_MHZ;

	typedef enum logic [2:0] {
		CAB_IDLE = 3'b001,
		CAB_CAL = 3'b010,
		CAB_DONE = 3'b100
	} cab_cal_state_t;
endpackage

// ===== logic/cab_reg_file.sv
// byte register file holding the analog control bank
// assumes writes come already decoded by the access port; writable bits are masked here
`timescale 1ns/1ns
module cab_reg_file
	import cab_pkg::*;
#(
	parameter int DEPTH = NUM_REGS
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic portRst_b,
	input wire logic wrEn,
	input wire logic [5:0] wrAddr,
	input wire logic [7:0] wrData,
	input wire logic [5:0] rdAddr,
	input wire logic [7:0] calResult,
	input wire logic calClear,
	output logic [7:0] rdData,
	output logic [DEPTH*8-1:0] regFlat
);
	initial begin
		if (DEPTH != NUM_REGS) $error("cab_reg_file depth must match the bank");
	end

	logic [7:0] rdData_next;

	// ----------------------------------------------------------------
	// one byte per offset, reset to the table value
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++) begin : g_reg
			localparam logic [7:0] RV = RESET_TABLE[gi*8 +: 8];
			localparam logic [7:0] WM = WMASK_TABLE[gi*8 +: 8];
			logic [7:0] byte_reg;
			logic [7:0] byte_next;
			wire hit = wrEn && (wrAddr == 6'(gi));
			wire clrCal = (6'(gi) == OFS_CALCTL) && calClear;
			always_comb begin
				byte_next = hit ? ((byte_reg & ~WM) | (wrData & WM)) : byte_reg;
				// write of one wins over the clear in the same cycle
				if (clrCal && !(hit && wrData[CAL_RESTART_BIT])) begin
					byte_next[CAL_RESTART_BIT] = 1'b0;
				end
			end
			// port reset puts the bank back to its defaults too
			always_ff @(posedge clk) begin
				if (!rst_b || !portRst_b) begin
					byte_reg <= RV;
				end else begin
					byte_reg <= byte_next;
				end
			end
			assign regFlat[gi*8 +: 8] = byte_reg;
		end
	endgenerate

	// read mux; result register returns the latched calibration result
	always_comb begin
		if (rdAddr == OFS_CALRES) begin
			rdData_next = {2'b00, calResult[5:0]};
		end else if (rdAddr < 6'(DEPTH)) begin
			rdData_next = regFlat[rdAddr*8 +: 8];
		end else begin
			rdData_next = 8'h00;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rdData <= 8'h00;
		end else begin
			rdData <= rdData_next;
		end
	end
endmodule

// ===== dv/cab_analog_bank_monitor.sv
// concurrent checks on the analog control bank ports
// assumes one clock domain and a bind onto every cab_analog_bank
`timescale 1ns/1ns
module cab_analog_bank_monitor
	import cab_pkg::*;
#(
	parameter int CAL_LEN = CAL_CYCLES
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic accWr,
	input wire logic [31:0] accWdata,
	input wire logic [31:0] accRdata,
	input wire logic [5:0] calValue,
	input wire logic analogPortReset_b,
	input wire logic ampClockGate,
	input wire logic ampEnable,
	input wire logic headphoneMute,
	input wire logic zeroCrossActive,
	input wire logic calBusy,
	input wire logic [NUM_REGS*8-1:0] bankFlat
);
	// slack for the done state and the clearing edge
	localparam int CAL_MAX = CAL_LEN + 4;
	logic [5:0] rdAddr_reg;
	logic [5:0] calRes_reg;

	// ----------------------------------------------------------------
	// helper logic
	// ----------------------------------------------------------------
	// last address handed in, so a readback has something to index
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rdAddr_reg <= 6'h00;
		end else if (accWr) begin
			rdAddr_reg <= accWdata[21:16];
		end
	end
	// expected result byte: measurement kept as the sequencer goes idle,
	// unless manual bias is chosen; port reset clears it like the bank
	always_ff @(posedge clk) begin
		if (!rst_b || !analogPortReset_b) begin
			calRes_reg <= 6'h00;
		end else if ($fell(calBusy) && $past(analogPortReset_b)
			&& !$past(bankFlat[168])) begin
			calRes_reg <= $past(calValue);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_port_reset_follow: assert property (
		accWr |=> analogPortReset_b == $past(accWdata[28]))
		else $error("port run bit not taken from access word");
	a_read_keeps_bank: assert property (
		accWr && !accWdata[24] && !calBusy |=> $stable(bankFlat))
		else $error("read access changed the bank");
	a_read_returns_byte: assert property (
		accWr && !accWdata[24] && accWdata[28] && accWdata[21:16] < 6'h18
		&& accWdata[21:16] != 6'h13 && !calBusy
		##1 !accWr && !calBusy |=> accRdata[7:0] == bankFlat[rdAddr_reg*8 +: 8])
		else $error("read byte differs from addressed register");
	a_gate_blocks_zc: assert property (
		zeroCrossActive == (bankFlat[151] && !bankFlat[7]))
		else $error("zero cross not forced off by clock gate");
	a_mute_on_zero: assert property (
		headphoneMute == (bankFlat[5:0] == 6'h00))
		else $error("mute does not follow zero volume code");
	a_cal_restart: assert property (
		accWr && accWdata[28] && accWdata[24] && accWdata[21:16] == 6'h15 && accWdata[9]
		&& analogPortReset_b && !calBusy |=> bankFlat[169] ##1 calBusy)
		else $error("restart bit did not start calibration");
	a_cal_clears_bit: assert property (
		$rose(calBusy) |-> ##[1:CAL_MAX] (!calBusy && !bankFlat[169]))
		else $error("restart bit not cleared after calibration");
	a_cal_result_latch: assert property (
		accWr && !accWdata[24] && accWdata[28] && accWdata[21:16] == 6'h13 && !calBusy
		##1 !accWr && !calBusy |=> accRdata[7:0] == {2'b00, calRes_reg})
		else $error("calibration result not latched");
	a_gate_from_reg: assert property (
		ampClockGate == bankFlat[7])
		else $error("clock gate does not follow its register bit");
	a_amp_held_cal: assert property (
		calBusy |-> !ampEnable)
		else $error("amp enabled during calibration");
endmodule

bind cab_analog_bank cab_analog_bank_monitor #(.CAL_LEN(CAL_LEN)) u_monitor (
	.clk, .rst_b, .accWr, .accWdata, .accRdata, .calValue, .analogPortReset_b,
	.ampClockGate, .ampEnable, .headphoneMute, .zeroCrossActive, .calBusy, .bankFlat);

// ===== dv/tb_codec_analog_ctrl_bank.sv
// self-checking bench for the analog control bank
// assumes cab_pkg is compiled first and the monitor is bound onto dut
`timescale 1ns/1ns
module tb_codec_analog_ctrl_bank;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic accWr = 1'b0;
	logic [31:0] accWdata = 32'h0;
	logic [31:0] accRdata;
	logic [5:0] calValue = 6'h00;
	logic ampEnableReq = 1'b0;
	logic analogPortReset_b, ampClockGate, ampEnable, headphoneMute;
	logic zeroCrossActive, zeroCrossLongTimeout, biasUseManual, calSingleShot, calBusy;
	logic [6:0] leftMixerSourceMask, rightMixerSourceMask;
	logic [5:0] headphoneVolume;
	logic [2:0] secondMicBoostGain, secondMicMixerGain, lineInputMixerGain, adcInputGain;
	logic rightAmpSourceSel, leftAmpSourceSel, rightAmpUnmute, leftAmpUnmute;
	logic headphoneBufferOn, headphoneInputPass, headphoneInputStageOn, headphoneOutputStageOn;
	logic [1:0] headphoneStartupDelay, detectPulldownDelay;
	logic [7:0] got, dat;
	logic [5:0] adr;
	int n_errors = 0;
	int cmp_count = 0;
	int seed = 32'hcd41;

	// short calibration so each run takes a handful of cycles
	cab_analog_bank #(.CAL_LEN(4)) dut (
		.clk, .rst_b, .accWr, .accWdata, .accRdata, .calValue, .ampEnableReq,
		.analogPortReset_b, .ampClockGate, .ampEnable, .headphoneVolume, .headphoneMute,
		.leftMixerSourceMask, .rightMixerSourceMask, .secondMicBoostGain,
		.secondMicMixerGain, .lineInputMixerGain, .adcInputGain, .rightAmpSourceSel,
		.leftAmpSourceSel, .rightAmpUnmute, .leftAmpUnmute, .zeroCrossActive,
		.zeroCrossLongTimeout, .biasUseManual, .calSingleShot, .calBusy, .headphoneBufferOn,
		.headphoneInputPass, .headphoneInputStageOn, .headphoneOutputStageOn,
		.headphoneStartupDelay, .detectPulldownDelay, .bankFlat());

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic print_verdict();
		if (n_errors == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one access word, held across exactly one sampling edge
	task automatic acc(input logic [31:0] w);
		@(negedge clk);
		accWr = 1'b1;
		accWdata = w;
		@(negedge clk);
		accWr = 1'b0;
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		acc({8'h11, 2'b00, a, d, 8'h00});
	endtask
	// read byte is registered twice, so wait one edge more
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		acc({8'h10, 2'b00, a, 16'h0000});
		@(negedge clk);
		d = accRdata[7:0];
	endtask
	task automatic waitCal();
		for (int k = 0; k < 40 && calBusy !== 1'b0; k++) begin
			@(negedge clk);
		end
		chk(calBusy, 1'b0, "calibration done");
	endtask
	task automatic calRun(input logic [7:0] d, input logic [7:0] res);
		wr(6'h15, d);
		repeat (2) @(negedge clk);
		chk(calBusy, 1'b1, "calibration running");
		chk({biasUseManual, calSingleShot}, {d[0], d[2]}, "cal mode");
		waitCal();
		rd(6'h15, got);
		chk(got, d & 8'hfd, "restart self clear");
		rd(6'h13, got);
		chk(got, res, "cal result");
	endtask
	function automatic logic [7:0] rstVal(input logic [5:0] a);
		case (a)
			6'h08: return 8'hb4;
			6'h09, 6'h0d: return 8'h03;
			6'h0e: return 8'h21;
			6'h0f: return 8'hd6;
			6'h10, 6'h11: return 8'h55;
			6'h12: return 8'h02;
			6'h14: return 8'h20;
			6'h16: return 8'hf1;
			6'h17: return 8'h04;
			default: return 8'h00;
		endcase
	endfunction
	// reserved bits and unmapped offsets read as zero
	function automatic logic [7:0] wMask(input logic [5:0] a);
		case (a)
			6'h00, 6'h08, 6'h0a, 6'h0f, 6'h10, 6'h11, 6'h14, 6'h15, 6'h16: return 8'hff;
			6'h01, 6'h02, 6'h0c: return 8'h7f;
			6'h09: return 8'h07;
			6'h0d: return 8'hf7;
			6'h0e: return 8'he3;
			6'h12: return 8'hc7;
			6'h17: return 8'hbf;
			default: return 8'h00;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// clock, watchdog and sequence
	// ----------------------------------------------------------------
	initial begin
		forever #4 clk = ~clk;
	end
	// whole sequence needs well under two thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		print_verdict();
	end
	initial begin
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		chk(analogPortReset_b, 1'b1, "port run at reset");
		chk({secondMicBoostGain, secondMicMixerGain}, 6'h23, "mic2 gain reset");
		chk({lineInputMixerGain, adcInputGain}, 6'h1b, "gain reset");
		chk({headphoneVolume, headphoneMute}, 7'h01, "volume reset");
		chk({headphoneBufferOn, headphoneInputPass}, 2'b11, "buffer reset");
		chk({headphoneInputStageOn, headphoneOutputStageOn}, 2'b11, "stage reset");
		chk(headphoneStartupDelay, 2'b00, "delay reset");
		for (int i = 0; i < 24; i++) begin
			rd(i[5:0], got);
			if (i != 19) chk(got, rstVal(i[5:0]), "reset value");
		end
		acc(32'h100e_5500);
		rd(6'h0e, got);
		chk(got, 8'h21, "read leaves register");
		for (int i = 0; i < 60; i++) begin
			adr = 6'($unsigned($random(seed)) % 24);
			dat = 8'($random(seed));
			calValue = 6'($random(seed));
			ampEnableReq = 1'($random(seed));
			if (adr == 6'h13) adr = 6'h14;
			if (adr == 6'h15) dat[1] = 1'b0;
			if (adr == 6'h17) dat[3] = 1'b0;
			wr(adr, dat);
			rd(adr, got);
			chk(got, dat & wMask(adr), "write readback");
		end
		wr(6'h09, 8'h05);
		acc(32'h0109_0600);
		chk(analogPortReset_b, 1'b0, "port held");
		acc(32'h1000_0000);
		rd(6'h09, got);
		chk(got, 8'h03, "port reset value");
		calValue = 6'h2a;
		ampEnableReq = 1'b1;
		wr(6'h17, 8'h84);
		repeat (2) @(negedge clk);
		chk(ampEnable, 1'b0, "amp held for cal");
		waitCal();
		chk(ampEnable, 1'b1, "amp after cal");
		calValue = 6'h15;
		calRun(8'h03, 8'h2a);
		calRun(8'h06, 8'h15);
		wr(6'h12, 8'hc0);
		wr(6'h00, 8'h00);
		chk({zeroCrossActive, zeroCrossLongTimeout, headphoneMute}, 3'b111, "zc on");
		wr(6'h00, 8'h81);
		chk({zeroCrossActive, ampClockGate, headphoneMute}, 3'b010, "zc gated");
		chk(headphoneVolume, 6'h01, "volume code");
		wr(6'h01, 8'hff);
		wr(6'h02, 8'hff);
		chk({leftMixerSourceMask, rightMixerSourceMask}, {7'h23, 7'h27}, "mixers");
		wr(6'h0a, 8'h09);
		chk({rightAmpUnmute, leftAmpUnmute}, 2'b10, "amp unmute");
		chk({rightAmpSourceSel, leftAmpSourceSel}, 2'b01, "amp source");
		wr(6'h16, 8'h58);
		chk({headphoneBufferOn, headphoneInputPass}, 2'b01, "buffer pass");
		chk({headphoneInputStageOn, headphoneOutputStageOn}, 2'b01, "stages");
		chk(headphoneStartupDelay, 2'b10, "startup delay");
		wr(6'h14, 8'h80);
		chk(detectPulldownDelay, 2'b10, "pulldown delay");
		wr(6'h08, 8'h27);
		wr(6'h09, 8'h05);
		wr(6'h0d, 8'h01);
		chk({secondMicBoostGain, secondMicMixerGain}, 6'h3a, "mic2 gains");
		chk({lineInputMixerGain, adcInputGain}, 6'h29, "line adc gains");
		print_verdict();
	end
endmodule
